// ### hdl/nv_host_pkg.sv
// Overview of operation
// RL1: write enable stays high during every read
// RL2: accesses only while store_busy_n is high
// RL3: write enable low at select keeps outputs off
// RL4: address changes only with select or write high
// RL5: command addresses decoded from thirteen bits only
// RL6: clock registers written by select or write edge
// RL7: low lane enable low before select or write
// RL8: power-up restore finishes within 20 ms
// RL9: unneeded store skipped; store ends within 8 ms
// RL10: writes stay enabled 25 ns after store start
// RL11: accesses ignored during store, recall, low supply
// RL12: six ordered command reads, write enable high
// RL13: command steps ended by select or output enable
// RL14: command acted within 100 us; recall 200 us
// RL15: sixth command read data may be invalid
// RL16: pin save pulse at least 15 ns low
// RL17: byte-wide select, write and output truth table
// RL18: byte lanes exist only in sixteen-bit mode
// RL19: each lane enable qualifies its own byte
// RL20: broken command sequence restarts the match
package nv_host_pkg;
  localparam int unsigned clk_period_ps = 4000;
  localparam int unsigned addr_w = 19;
  localparam int unsigned data_w = 16;
  // cycle timing, derived from the printed figures
  localparam int unsigned access_ns = 25;
  localparam int unsigned access_cycles = (access_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
  localparam int unsigned write_pulse_ns = 20;
  localparam int unsigned write_cycles =
    (write_pulse_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
  localparam int unsigned pin_save_pulse_width_ns = 15;
  localparam int unsigned pin_save_cycles =
    (pin_save_pulse_width_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
  localparam int unsigned no_latch_release_time_ns = 25;
  localparam int unsigned release_cycles =
    (no_latch_release_time_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
  localparam int unsigned powerup_restore_time_ms = 20;
  localparam int unsigned store_time_ms = 8;
  localparam int unsigned soft_seq_time_us = 100;
  localparam int unsigned soft_recall_time_us = 200;
  localparam int unsigned cycles_per_us = 1000000 / clk_period_ps;
  localparam int unsigned restore_cycles_dflt = powerup_restore_time_ms * 1000 * cycles_per_us;
  localparam int unsigned store_cycles_dflt = store_time_ms * 1000 * cycles_per_us;
  localparam int unsigned soft_store_cycles_dflt =
    (soft_seq_time_us * cycles_per_us) + store_cycles_dflt;
  localparam int unsigned soft_recall_cycles_dflt =
    (soft_seq_time_us + soft_recall_time_us) * cycles_per_us;
  localparam int unsigned timer_w = 24;
  // host operation codes
  typedef enum logic [2:0] {
    op_read = 3'h0,
    op_write = 3'h1,
    op_soft_store = 3'h2,
    op_soft_recall = 3'h3,
    op_pin_save = 3'h4
  } op_e;
  localparam int unsigned cmd_steps = 6;
  // command read sequences, low thirteen decode bits sit at A14..A2
  localparam logic [addr_w-1:0] cmd_addr_mask = 19'h0_7FFC;
  localparam logic [addr_w-1:0] store_seq [cmd_steps] = '{
    19'h0_4E38, 19'h0_B1C4, 19'h0_83E0, 19'h0_7C1C, 19'h0_703F, 19'h0_8FC0};
  localparam logic [addr_w-1:0] recall_seq [cmd_steps] = '{
    19'h0_4E38, 19'h0_B1C4, 19'h0_83E0, 19'h0_7C1C, 19'h0_703F, 19'h0_4C63};
endpackage

// ### hdl/nv_host_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module nv_host_ctrl #(
  parameter int unsigned restore_cycles = nv_host_pkg::restore_cycles_dflt,
  parameter int unsigned store_cycles = nv_host_pkg::store_cycles_dflt,
  parameter int unsigned soft_store_cycles = nv_host_pkg::soft_store_cycles_dflt,
  parameter int unsigned soft_recall_cycles = nv_host_pkg::soft_recall_cycles_dflt,
  parameter bit wide_mode = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire nv_host_pkg::op_e req_op,
  input wire logic [nv_host_pkg::addr_w-1:0] req_addr,
  input wire logic [nv_host_pkg::data_w-1:0] req_wdata,
  input wire logic [1:0] req_lanes,
  output logic req_ready,
  output logic rsp_valid,
  output logic [nv_host_pkg::data_w-1:0] rsp_rdata,
  output logic chip_en_n,
  output logic write_en_n,
  output logic out_en_n,
  output logic upper_byte_lane_n,
  output logic lower_byte_lane_n,
  output logic [nv_host_pkg::addr_w-1:0] mem_addr,
  output logic [nv_host_pkg::data_w-1:0] dq_out,
  output logic dq_oe,
  input wire logic [nv_host_pkg::data_w-1:0] dq_in,
  output logic store_busy_out_n,
  output logic store_busy_oe,
  input wire logic store_busy_in_n,
  output logic access_inhibited
);
  import nv_host_pkg::*;

  typedef enum logic [3:0] {
    st_restore = 4'h0,
    st_idle = 4'h1,
    st_setup = 4'h2,
    st_strobe = 4'h3,
    st_hold = 4'h4,
    st_save_pulse = 4'h5,
    st_save_wait = 4'h6,
    st_lockout = 4'h7
  } state_e;

  state_e state;
  logic [timer_w-1:0] timer;
  op_e op;
  logic [2:0] step;
  logic [nv_host_pkg::data_w-1:0] wdata;
  logic [1:0] lanes;
  logic [2:0] busy_sync;
  logic busy_low;

  // command address for one step, masked to the decode bits
  function automatic logic [addr_w-1:0] cmd_addr(input op_e o, input logic [2:0] s);
    logic [addr_w-1:0] a;
    a = (o == op_soft_recall) ? recall_seq[s] : store_seq[s];
    return a & cmd_addr_mask; // [RL5]
  endfunction

  // store_busy_n is a pin: three stages, accept when last two agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_sync <= 3'h7;
      busy_low <= 1'b0;
    end else begin
      busy_sync <= {busy_sync[1:0], store_busy_in_n};
      if (busy_sync[1] == busy_sync[2]) begin
        busy_low <= ~busy_sync[2];
      end
    end
  end

  // main access sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= st_restore;
      timer <= timer_w'(restore_cycles);
      op <= op_read;
      step <= 3'h0;
      wdata <= '0;
      lanes <= 2'h0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      chip_en_n <= 1'b1;
      write_en_n <= 1'b1;
      out_en_n <= 1'b1;
      upper_byte_lane_n <= 1'b1;
      lower_byte_lane_n <= 1'b1;
      mem_addr <= '0;
      dq_out <= '0;
      dq_oe <= 1'b0;
      store_busy_out_n <= 1'b1;
      store_busy_oe <= 1'b0;
      access_inhibited <= 1'b1;
    end else begin
      rsp_valid <= 1'b0;
      unique case (state)
        // wait out power-up restore before any access
        st_restore: begin
          if (timer == '0) begin // [RL8]
            state <= st_idle;
            req_ready <= 1'b1;
            access_inhibited <= 1'b0;
          end else begin
            timer <= timer - 1'b1;
          end
        end
        st_idle: begin
          // device-driven busy means a store runs; hold off all cycles
          if (busy_low) begin // [RL2] [RL11]
            req_ready <= 1'b0;
            access_inhibited <= 1'b1;
          end else if (access_inhibited) begin
            req_ready <= 1'b1;
            access_inhibited <= 1'b0;
          end else if (req_valid) begin
            req_ready <= 1'b0;
            op <= req_op;
            step <= 3'h0;
            wdata <= req_wdata;
            lanes <= wide_mode ? req_lanes : 2'h3; // [RL18]
            if (req_op == op_pin_save) begin
              store_busy_out_n <= 1'b0; // [RL16]
              store_busy_oe <= 1'b1;
              timer <= timer_w'(pin_save_cycles);
              access_inhibited <= 1'b1;
              state <= st_save_pulse;
            end else begin
              // address settles while select and write are high
              mem_addr <= (req_op == op_read || req_op == op_write) ?
                req_addr : cmd_addr(req_op, 3'h0); // [RL4]
              // lanes settle a cycle before the select edge, as clock writes need
              upper_byte_lane_n <= ~(req_lanes[1] | ~wide_mode); // [RL19]
              lower_byte_lane_n <= ~(req_lanes[0] | ~wide_mode | (req_op == op_write)); // [RL7]
              state <= st_setup;
            end
          end
        end
        // assert byte lanes before the select edge
        st_setup: begin
          upper_byte_lane_n <= ~lanes[1]; // [RL19]
          lower_byte_lane_n <= ~(lanes[0] | (op == op_write)); // [RL7]
          if (op == op_write) begin
            dq_out <= wdata;
            dq_oe <= 1'b1;
            write_en_n <= 1'b0; // [RL3] [RL6]
            timer <= timer_w'(write_cycles);
          end else begin
            write_en_n <= 1'b1; // [RL1] [RL12]
            out_en_n <= 1'b0;
            timer <= timer_w'(access_cycles);
          end
          chip_en_n <= 1'b0; // select ends the cycle [RL13] [RL17]
          state <= st_strobe;
        end
        st_strobe: begin
          if (timer != '0) begin
            timer <= timer - 1'b1;
          end else begin
            if (op == op_read) begin
              // the upper byte is only present in the wide mode
              rsp_rdata <= wide_mode ? dq_in : {8'h00, dq_in[7:0]};
            end
            chip_en_n <= 1'b1;
            write_en_n <= 1'b1;
            out_en_n <= 1'b1;
            state <= st_hold;
          end
        end
        st_hold: begin
          dq_oe <= 1'b0;
          if ((op == op_soft_store || op == op_soft_recall) && step != 3'(cmd_steps - 1)) begin
            // reads follow back to back, so no other access breaks the partial match
            // lanes stay low so the next select edge finds them settled
            step <= step + 1'b1; // [RL20]
            mem_addr <= cmd_addr(op, step + 1'b1); // [RL12]
            state <= st_setup;
          end else if (op == op_soft_store || op == op_soft_recall) begin
            // sixth read data is not trusted [RL15]
            upper_byte_lane_n <= 1'b1;
            lower_byte_lane_n <= 1'b1;
            timer <= timer_w'((op == op_soft_recall) ? soft_recall_cycles : soft_store_cycles);
            access_inhibited <= 1'b1; // [RL14]
            state <= st_lockout;
          end else begin
            upper_byte_lane_n <= 1'b1;
            lower_byte_lane_n <= 1'b1;
            rsp_valid <= 1'b1;
            req_ready <= 1'b1;
            state <= st_idle;
          end
        end
        // pin save low pulse, then release the pin
        st_save_pulse: begin
          if (timer != '0) begin
            timer <= timer - 1'b1;
          end else begin
            store_busy_out_n <= 1'b1;
            store_busy_oe <= 1'b0;
            timer <= timer_w'(release_cycles); // skipped store releases fast [RL9]
            state <= st_save_wait;
          end
        end
        // device may hold busy low while it stores; allow the full time
        st_save_wait: begin
          if (timer != '0) begin
            timer <= timer - 1'b1;
          end else if (!busy_low) begin // [RL10]
            rsp_valid <= 1'b1;
            req_ready <= 1'b1;
            access_inhibited <= 1'b0;
            state <= st_idle;
          end else begin
            timer <= timer_w'(store_cycles); // [RL9]
          end
        end
        st_lockout: begin
          if (timer != '0) begin
            timer <= timer - 1'b1; // [RL11]
          end else begin
            rsp_valid <= 1'b1;
            req_ready <= 1'b1;
            access_inhibited <= 1'b0;
            state <= st_idle;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### testbench/nv_host_ctrl_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module nv_host_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire nv_host_pkg::op_e req_op,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic chip_en_n,
  input wire logic write_en_n,
  input wire logic out_en_n,
  input wire logic lower_byte_lane_n,
  input wire logic [nv_host_pkg::addr_w-1:0] mem_addr,
  input wire logic dq_oe,
  input wire logic store_busy_out_n,
  input wire logic store_busy_oe,
  input wire logic access_inhibited
);
  import nv_host_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // strobe relations, each tied to its cause
  property p_rd_we; !out_en_n |-> write_en_n; endproperty
  property p_busy; !chip_en_n |-> !access_inhibited; endproperty
  property p_addr; !chip_en_n && !write_en_n |-> $stable(mem_addr); endproperty
  property p_ble; $fell(write_en_n) |-> !$past(lower_byte_lane_n); endproperty
  property p_cmd; req_valid && req_ready && req_op == op_soft_store |=> write_en_n[*8]; endproperty
  property p_pin; $rose(store_busy_oe) |-> !store_busy_out_n[*4]; endproperty
  property p_bus; dq_oe |-> out_en_n; endproperty
  property p_lat; req_valid && req_ready && req_op == op_read |-> ##[9:11] rsp_valid; endproperty
  a_rd_we: assert property (p_rd_we) else $error("oe low during write");
  a_busy: assert property (p_busy) else $error("select while inhibited");
  a_addr: assert property (p_addr) else $error("address moved in write");
  a_ble: assert property (p_ble) else $error("low lane late");
  a_cmd: assert property (p_cmd) else $error("write in command");
  a_pin: assert property (p_pin) else $error("save pulse short");
  a_bus: assert property (p_bus) else $error("bus contention");
  a_lat: assert property (p_lat) else $error("read answer late");
  c_rd: cover property (!out_en_n);
  c_wr: cover property ($fell(write_en_n));
  c_pin: cover property ($rose(store_busy_oe));
endmodule
bind nv_host_ctrl nv_host_chk u_chk (.clk, .nrst, .req_valid, .req_op, .req_ready, .rsp_valid,
  .chip_en_n, .write_en_n, .out_en_n, .lower_byte_lane_n, .mem_addr, .dq_oe, .store_busy_out_n,
  .store_busy_oe, .access_inhibited);
`default_nettype wire

// ### testbench/nv_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module nv_dev_model #(
  parameter int busy_len = 30
) (
  input wire logic clk,
  input wire logic chip_en_n,
  input wire logic write_en_n,
  input wire logic out_en_n,
  input wire logic upper_byte_lane_n,
  input wire logic lower_byte_lane_n,
  input wire logic [nv_host_pkg::addr_w-1:0] mem_addr,
  input wire logic [15:0] dq_out,
  input wire logic store_busy,
  output logic [15:0] dq_in,
  output logic busy_drv
);
  import nv_host_pkg::*;
  logic [15:0] mem [logic [18:0]];
  logic [15:0] nv [logic [18:0]];
  logic [15:0] last = 16'h0000;
  logic [18:0] a;
  logic ce_q = 1'b1;
  logic hsb_q = 1'b1;
  logic dirty = 1'b0;
  int step = 0;
  int cnt = busy_len; // power-up restore still running at start
  int stores = 0;
  int recalls = 0;
  assign busy_drv = cnt != 0;
  // undriven lanes show the inverse of the last value, not a stale copy
  always_comb begin
    dq_in = ~last;
    if (!chip_en_n && write_en_n && !out_en_n && cnt == 0 && mem.exists(mem_addr)) begin
      if (!lower_byte_lane_n) dq_in[7:0] = mem[mem_addr][7:0];
      if (!upper_byte_lane_n) dq_in[15:8] = mem[mem_addr][15:8];
    end
  end
  // behavioural store, recall and command matcher
  always @(posedge clk) begin
    last = dq_in;
    a = mem_addr & cmd_addr_mask;
    if (cnt != 0) cnt = cnt - 1;
    else if (!chip_en_n && !write_en_n) begin
      if (!lower_byte_lane_n) mem[mem_addr][7:0] = dq_out[7:0];
      if (!upper_byte_lane_n) mem[mem_addr][15:8] = dq_out[15:8];
      dirty = 1'b1;
      step = 0;
    end else if (!ce_q && chip_en_n) begin
      if (step == 5 && a == (recall_seq[5] & cmd_addr_mask)) begin
        mem = nv;
        recalls++;
        cnt = busy_len;
        step = 0;
      end else if (a == (store_seq[step] & cmd_addr_mask)) step++;
      else step = 0;
      if (step == 6) begin
        nv = mem;
        stores++;
        dirty = 1'b0;
        cnt = busy_len;
        step = 0;
      end
    end
    // a save with nothing written is skipped and the line released at once
    if (!store_busy && hsb_q && cnt == 0 && dirty) begin
      nv = mem; // a write on this same edge has landed first
      stores++;
      dirty = 1'b0;
      cnt = busy_len;
    end
    ce_q = chip_en_n;
    hsb_q = store_busy;
  end
endmodule
`default_nettype wire

// ### testbench/nv_host_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module nv_host_ctrl_tb_top;
  import nv_host_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  op_e req_op = op_read;
  logic [18:0] req_addr = 19'h0_0000;
  logic [18:0] mem_addr, a;
  logic [15:0] req_wdata = 16'h0000;
  logic [15:0] rdata, d, rsp_rdata, dq_out, dq_in;
  logic [1:0] req_lanes = 2'b11;
  logic [1:0] l;
  logic req_ready, rsp_valid, ce_n, we_n, oe_n, ub_n, lb_n, dq_oe, sb_n, sb_oe, inh, busy_drv;
  int bad_count = 0;
  int samples_checked = 0;
  // pulled-up busy line, low while either party pulls it
  wire logic sb_wire = !(sb_oe && !sb_n) && !busy_drv;
  always #2 clk = ~clk;
  nv_host_ctrl #(.restore_cycles(10), .store_cycles(20), .soft_store_cycles(20),
    .soft_recall_cycles(20), .wide_mode(1'b1)) u_dut (.clk(clk), .nrst(nrst),
    .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_lanes(req_lanes), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .chip_en_n(ce_n), .write_en_n(we_n), .out_en_n(oe_n), .upper_byte_lane_n(ub_n),
    .lower_byte_lane_n(lb_n), .mem_addr(mem_addr), .dq_out(dq_out), .dq_oe(dq_oe),
    .dq_in(dq_in), .store_busy_out_n(sb_n), .store_busy_oe(sb_oe), .store_busy_in_n(sb_wire),
    .access_inhibited(inh));
  nv_dev_model u_mdl (.clk(clk), .chip_en_n(ce_n), .write_en_n(we_n), .out_en_n(oe_n),
    .upper_byte_lane_n(ub_n), .lower_byte_lane_n(lb_n), .mem_addr(mem_addr), .dq_out(dq_out),
    .store_busy(sb_wire), .dq_in(dq_in), .busy_drv(busy_drv));
  function automatic logic [15:0] lane_mask(input logic [1:0] m);
    return {{8{m[1]}}, {8{m[0]}}};
  endfunction
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one request, held until its answer: a busy device may refuse it while ready
  task automatic do_op(input op_e op, input logic [18:0] ad, input logic [15:0] wd);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
    end
    req_op = op;
    req_addr = ad;
    req_wdata = wd;
    req_lanes = l;
    req_valid = 1'b1;
    while (rsp_valid !== 1'b1 && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
    end
    req_valid = 1'b0;
    if (n >= 4000) bad_count++;
    rdata = rsp_rdata;
    // one edge apart, so the next call never raises valid in this time step
    @(posedge clk);
    #1;
  endtask
  initial begin
    void'($urandom(22));
    repeat (2) @(posedge clk);
    #1;
    chk("inhibit in reset", 16'h0001, {15'h0000, inh});
    nrst = 1'b1;
    // random words plus both address extremes, read back per lane
    for (int i = 0; i < 10; i++) begin
      a = (i == 0) ? 19'h7_FFFF : (i == 1) ? 19'h0_0000 : 19'($urandom);
      d = 16'($urandom);
      l = 2'b11;
      do_op(op_write, a, d);
      l = 2'(i % 3 + 1);
      do_op(op_read, a, 16'h0000);
      chk("read lanes", d & lane_mask(l), rdata & lane_mask(l));
    end
    $display("test rw done");
    l = 2'b11;
    a = 19'h0_1234;
    do_op(op_write, a, 16'h1111);
    do_op(op_soft_store, a, 16'h0000);
    chk("stores", 16'h0001, 16'(u_mdl.stores));
    do_op(op_write, a, 16'h2222);
    do_op(op_soft_recall, a, 16'h0000);
    do_op(op_read, a, 16'h0000);
    chk("recalled", 16'h1111, rdata);
    $display("test soft done");
    do_op(op_write, a, 16'h3333);
    do_op(op_pin_save, a, 16'h0000);
    chk("pin save", 16'h0002, 16'(u_mdl.stores));
    do_op(op_pin_save, a, 16'h0000);
    chk("skipped save", 16'h0002, 16'(u_mdl.stores));
    do_op(op_read, a, 16'h0000);
    chk("after save", 16'h3333, rdata);
    $display("test pin done");
    print_verdict();
  end
  // about ninety times the expected run
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
